// ### hdl/msf_pkg.sv
// shared constants for the special function register group and its controller
package msf_pkg;
	// special function register addresses
	localparam logic [7:0] SFR_ERASE    = 8'h94;
	localparam logic [7:0] SFR_EE_DATA  = 8'h9E;
	localparam logic [7:0] SFR_EE_CTRL  = 8'h9F;
	localparam logic [7:0] SFR_FLASH_CTL = 8'hB2;
	localparam logic [7:0] SFR_PAGE_SEL = 8'hB7;
	localparam logic [7:0] SFR_WD_FLAGS = 8'hE8;
	localparam logic [7:0] SFR_IRQ_LVL  = 8'hF8;
	// erase command codes
	localparam logic [7:0] ERASE_PAGE_CODE = 8'h55;
	localparam logic [7:0] ERASE_MASS_CODE = 8'hAA;
	// eeprom transmit command code
	localparam logic [7:0] EE_TX_CODE = 8'h01;
	// flash control field positions
	localparam int FC_PWE     = 0;
	localparam int FC_MEEN    = 1;
	localparam int FC_SECURE  = 6;
	localparam int FC_PREBOOT = 7;
	// watchdog and event flag field positions
	localparam int WF_XFER   = 0;
	localparam int WF_RTC    = 1;
	localparam int WF_WATCHDOG_RESTART = 7;
	// reset value and irq line count
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int         IRQ_LINES = 7;
	// controller register offsets and response codes on the AXI4-Lite side
	localparam logic [4:0] CR_ADDR   = 5'h00;
	localparam logic [4:0] CR_WDATA  = 5'h04;
	localparam logic [4:0] CR_RDCMD  = 5'h08;
	localparam logic [4:0] CR_RDATA  = 5'h0C;
	localparam logic [4:0] CR_CTRL   = 5'h10;
	localparam logic [4:0] CR_EXTERNAL_DATA_MOVE   = 5'h14;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : msf_pkg

// ### hdl/msf_sfr_if.sv
// special function register bus between the mpu controller and the register group
`timescale 1ns/10ps
interface msf_sfr_if;
	logic [7:0]  sfr_addr;
	logic [7:0]  sfr_wdata;
	logic        sfr_we;
	logic        sfr_re;
	logic [7:0]  sfr_rdata;
	logic        int_enabled;
	logic        external_data_move_wr;
	logic [15:0] external_data_move_addr;
	logic [7:0]  external_data_move_data;
	modport dev (
		input  sfr_addr, sfr_wdata, sfr_we, sfr_re, int_enabled, external_data_move_wr, external_data_move_addr, external_data_move_data,
		output sfr_rdata
	);
	modport mpu (
		output sfr_addr, sfr_wdata, sfr_we, sfr_re, int_enabled, external_data_move_wr, external_data_move_addr, external_data_move_data,
		input  sfr_rdata
	);
endinterface : msf_sfr_if

// ### hdl/msf_sfr_bank.sv
// device end: flash, eeprom, watchdog and interrupt special function registers
//
// Design decision made elsewhere: the AXI4-Lite slave port sits in msf_mpu_ctrl, not here.
`timescale 1ns/10ps
// What this block does
// - 0x55 to erase register starts page erase
// - 0xAA starts mass erase if enabled, debug
// - erase register write-only, other codes ignored
// - software sets page 0..127 before each erase
// - program write enable steers moves to flash
// - program write enable clears after flash byte
// - program write enable writes ignored while interrupts enabled
// - mass erase enable resets zero, rewrite each
// - security bit set-only, cleared by reset
// - preboot status bit reads high while active
// - flag register written whole byte, ones keep
// - transfer flag set by hardware, handler clears
// - one-second flag set by hardware, handler clears
// - writing one restarts the watchdog
// - irq level register shows live inputs
module msf_sfr_bank (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// register bus
	msf_sfr_if.dev           bus,
	// flash erase and program
	input  wire logic        debug_port_en,
	output logic             page_erase_start,
	output logic [6:0]       page_erase_page,
	output logic             mass_erase_start,
	output logic             flash_wr,
	output logic             data_ram_wr,
	output logic [15:0]      mem_wr_addr,
	output logic [7:0]       mem_wr_data,
	output logic             secure,
	input  wire logic        preboot_pin,
	// eeprom
	output logic             eeprom_tx_start,
	output logic [7:0]       eeprom_data_byte,
	output logic [7:0]       eeprom_command_control,
	// watchdog and events
	input  wire logic        transfer_busy_event,
	input  wire logic        one_second_tick,
	output logic             watchdog_restart,
	output logic             transfer_event_flag,
	output logic             clock_second_event_flag,
	// external interrupt pins
	input  wire logic [6:0]  external_irq_inputs
);
	logic [7:0] flash_page_select;
	logic       program_write_enable;
	logic       mass_erase_enable;
	logic       preboot_s1;
	logic       preboot_s2;
	logic [6:0] irq_s1;
	logic [6:0] irq_s2;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		hit = bus.sfr_we && (a == reg_addr);
	endfunction : hit

	wire        wr_erase   = hit(bus.sfr_addr, msf_pkg::SFR_ERASE);
	wire        wr_eeprom_data_byte  = hit(bus.sfr_addr, msf_pkg::SFR_EE_DATA);
	wire        wr_eeprom_command_control  = hit(bus.sfr_addr, msf_pkg::SFR_EE_CTRL);
	wire        wr_fctl    = hit(bus.sfr_addr, msf_pkg::SFR_FLASH_CTL);
	wire        wr_page    = hit(bus.sfr_addr, msf_pkg::SFR_PAGE_SEL);
	wire        wr_flags   = hit(bus.sfr_addr, msf_pkg::SFR_WD_FLAGS);
	wire        do_page    = wr_erase && (bus.sfr_wdata == msf_pkg::ERASE_PAGE_CODE);
	wire        do_mass    = wr_erase && (bus.sfr_wdata == msf_pkg::ERASE_MASS_CODE)
	                         && mass_erase_enable && debug_port_en;
	wire        pwe_wr_ok  = wr_fctl && !bus.int_enabled;
	wire        flash_move = bus.external_data_move_wr && program_write_enable;
	// event sets take priority over the clearing write; ones in the write keep a flag
	wire        next_xfer  = transfer_busy_event
	                         || (transfer_event_flag && !(wr_flags && !bus.sfr_wdata[msf_pkg::WF_XFER]));
	wire        next_rtc   = one_second_tick
	                         || (clock_second_event_flag && !(wr_flags && !bus.sfr_wdata[msf_pkg::WF_RTC]));
	wire [7:0]  fctl_read  = {preboot_s2, secure, 4'h0, mass_erase_enable, program_write_enable};
	wire [7:0]  flags_read = {6'h00, clock_second_event_flag, transfer_event_flag};
	logic [7:0] next_rdata;

	always_comb begin
		case (bus.sfr_addr)
			msf_pkg::SFR_EE_DATA:   next_rdata = eeprom_data_byte;
			msf_pkg::SFR_EE_CTRL:   next_rdata = eeprom_command_control;
			msf_pkg::SFR_FLASH_CTL: next_rdata = fctl_read;
			msf_pkg::SFR_PAGE_SEL:  next_rdata = flash_page_select;
			msf_pkg::SFR_WD_FLAGS:  next_rdata = flags_read;
			msf_pkg::SFR_IRQ_LVL:   next_rdata = {1'b0, irq_s2};
			default:                next_rdata = msf_pkg::RST_BYTE;
		endcase
	end

	// pin synchronisers; the irq levels are only sampled, never held beyond two stages
	always_ff @(posedge aclk) begin
		preboot_s1 <= preboot_pin;
		preboot_s2 <= preboot_s1;
		irq_s1     <= external_irq_inputs;
		irq_s2     <= irq_s1;
	end

	// page address and eeprom pair
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flash_page_select      <= msf_pkg::RST_BYTE;
			eeprom_data_byte       <= msf_pkg::RST_BYTE;
			eeprom_command_control <= msf_pkg::RST_BYTE;
		end else begin
			if (wr_page)
				flash_page_select <= bus.sfr_wdata;
			if (wr_eeprom_data_byte)
				eeprom_data_byte <= bus.sfr_wdata;
			if (wr_eeprom_command_control)
				eeprom_command_control <= bus.sfr_wdata;
		end
	end

	// flash control bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			program_write_enable <= 1'b0;
			mass_erase_enable    <= 1'b0;
			secure               <= 1'b0;
		end else begin
			if (flash_move)
				program_write_enable <= 1'b0;
			else if (pwe_wr_ok)
				program_write_enable <= bus.sfr_wdata[msf_pkg::FC_PWE];
			if (do_mass)
				mass_erase_enable <= 1'b0;
			else if (wr_fctl)
				mass_erase_enable <= bus.sfr_wdata[msf_pkg::FC_MEEN];
			if (wr_fctl && bus.sfr_wdata[msf_pkg::FC_SECURE])
				secure <= 1'b1;
		end
	end

	// strobes and read data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			page_erase_start        <= 1'b0;
			page_erase_page         <= 7'h00;
			mass_erase_start        <= 1'b0;
			flash_wr                <= 1'b0;
			data_ram_wr             <= 1'b0;
			mem_wr_addr             <= 16'h0000;
			mem_wr_data             <= 8'h00;
			eeprom_tx_start         <= 1'b0;
			watchdog_restart        <= 1'b0;
			transfer_event_flag     <= 1'b0;
			clock_second_event_flag <= 1'b0;
			bus.sfr_rdata           <= msf_pkg::RST_BYTE;
		end else begin
			page_erase_start <= do_page;
			if (do_page)
				page_erase_page <= flash_page_select[6:0];
			mass_erase_start <= do_mass;
			flash_wr         <= flash_move;
			data_ram_wr      <= bus.external_data_move_wr && !program_write_enable;
			if (bus.external_data_move_wr) begin
				mem_wr_addr <= bus.external_data_move_addr;
				mem_wr_data <= bus.external_data_move_data;
			end
			eeprom_tx_start  <= wr_eeprom_command_control && (bus.sfr_wdata == msf_pkg::EE_TX_CODE);
			watchdog_restart <= wr_flags && bus.sfr_wdata[msf_pkg::WF_WATCHDOG_RESTART];
			transfer_event_flag     <= next_xfer;
			clock_second_event_flag <= next_rtc;
			if (bus.sfr_re)
				bus.sfr_rdata <= next_rdata;
		end
	end
endmodule : msf_sfr_bank

// ### hdl/msf_mpu_ctrl.sv
// mpu end: AXI4-Lite controlled driver of the special function register bus
`timescale 1ns/10ps
module msf_mpu_ctrl (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [4:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [4:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// register bus
	msf_sfr_if.mpu           bus
);
	logic       rd_pending;
	logic       rd_done;
	logic [7:0] rd_result;

	wire        w_hs   = awvalid && awready && wvalid && wready;
	wire        ar_hs  = arvalid && arready;
	wire        w_ok   = (awaddr == msf_pkg::CR_ADDR) || (awaddr == msf_pkg::CR_WDATA)
	                     || (awaddr == msf_pkg::CR_RDCMD) || (awaddr == msf_pkg::CR_CTRL)
	                     || (awaddr == msf_pkg::CR_EXTERNAL_DATA_MOVE);
	// partial writes would break the whole-byte discipline of the flag register
	wire        w_full = (wstrb == 4'hF);
	wire        w_go   = w_hs && w_ok && w_full;
	logic [31:0] next_rdata;
	logic        next_rok;

	always_comb begin
		next_rok = 1'b1;
		case (araddr)
			msf_pkg::CR_ADDR:  next_rdata = {24'h000000, bus.sfr_addr};
			msf_pkg::CR_RDATA: next_rdata = {23'h000000, rd_done, rd_result};
			msf_pkg::CR_CTRL:  next_rdata = {31'h00000000, bus.int_enabled};
			msf_pkg::CR_EXTERNAL_DATA_MOVE:  next_rdata = {8'h00, bus.external_data_move_addr, bus.external_data_move_data};
			default: begin
				next_rdata = 32'h00000000;
				next_rok   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= msf_pkg::RESP_OKAY;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rresp   <= msf_pkg::RESP_OKAY;
			rdata   <= 32'h00000000;
		end else begin
			awready <= awvalid && wvalid && !awready && !bvalid;
			wready  <= awvalid && wvalid && !awready && !bvalid;
			if (w_hs) begin
				bvalid <= 1'b1;
				bresp  <= w_go ? msf_pkg::RESP_OKAY : msf_pkg::RESP_SLVERR;
			end else if (bready)
				bvalid <= 1'b0;
			arready <= arvalid && !arready && !rvalid;
			if (ar_hs) begin
				rvalid <= 1'b1;
				rdata  <= next_rdata;
				rresp  <= next_rok ? msf_pkg::RESP_OKAY : msf_pkg::RESP_SLVERR;
			end else if (rready)
				rvalid <= 1'b0;
		end
	end

	// special function register bus side; every register write is a whole byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus.sfr_addr    <= msf_pkg::RST_BYTE;
			bus.sfr_wdata   <= msf_pkg::RST_BYTE;
			bus.sfr_we      <= 1'b0;
			bus.sfr_re      <= 1'b0;
			bus.int_enabled <= 1'b0;
			bus.external_data_move_wr     <= 1'b0;
			bus.external_data_move_addr   <= 16'h0000;
			bus.external_data_move_data   <= 8'h00;
			rd_pending      <= 1'b0;
			rd_done         <= 1'b0;
			rd_result       <= 8'h00;
		end else begin
			bus.sfr_we  <= w_go && (awaddr == msf_pkg::CR_WDATA);
			bus.sfr_re  <= w_go && (awaddr == msf_pkg::CR_RDCMD);
			bus.external_data_move_wr <= w_go && (awaddr == msf_pkg::CR_EXTERNAL_DATA_MOVE);
			if (w_go && awaddr == msf_pkg::CR_ADDR)
				bus.sfr_addr <= wdata[7:0];
			if (w_go && awaddr == msf_pkg::CR_WDATA)
				bus.sfr_wdata <= wdata[7:0];
			if (w_go && awaddr == msf_pkg::CR_CTRL)
				bus.int_enabled <= wdata[0];
			if (w_go && awaddr == msf_pkg::CR_EXTERNAL_DATA_MOVE) begin
				bus.external_data_move_addr <= wdata[23:8];
				bus.external_data_move_data <= wdata[7:0];
			end
			rd_pending <= bus.sfr_re;
			if (w_go && awaddr == msf_pkg::CR_RDCMD)
				rd_done <= 1'b0;
			else if (rd_pending) begin
				rd_done   <= 1'b1;
				rd_result <= bus.sfr_rdata;
			end
		end
	end
endmodule : msf_mpu_ctrl

// ### tb/msf_sfr_asserts.sv
// concurrent checks on the register bus and the device end outputs
`timescale 1ns/10ps
module msf_sfr_asserts (
	// clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// register bus
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_we,
	input wire logic       external_data_move_wr,
	input wire logic [7:0] external_data_move_data,
	// device end
	input wire logic       page_erase_start,
	input wire logic       mass_erase_start,
	input wire logic       flash_wr,
	input wire logic       data_ram_wr,
	input wire logic [7:0] mem_wr_data,
	input wire logic       secure,
	input wire logic       eeprom_tx_start,
	input wire logic       watchdog_restart,
	input wire logic       transfer_busy_event,
	input wire logic       transfer_event_flag
);
	wire erase_wr = sfr_we && sfr_addr == msf_pkg::SFR_ERASE;
	wire page_wr  = erase_wr && sfr_wdata == msf_pkg::ERASE_PAGE_CODE;
	wire mass_wr  = erase_wr && sfr_wdata == msf_pkg::ERASE_MASS_CODE;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr(a, d);
		sfr_we && sfr_addr == a && sfr_wdata == d;
	endsequence
	a_page_go: assert property (page_wr |=> page_erase_start)
		else $error("page erase not started");
	a_page_cause: assert property (page_erase_start |-> $past(page_wr))
		else $error("page erase without its code");
	a_mass_cause: assert property (mass_erase_start |-> $past(mass_wr))
		else $error("mass erase without its code");
	a_move_route: assert property (external_data_move_wr |=> flash_wr != data_ram_wr && mem_wr_data == $past(external_data_move_data))
		else $error("data move misrouted");
	a_secure_hold: assert property (secure |=> secure)
		else $error("security bit dropped");
	a_ee_launch: assert property (s_wr(msf_pkg::SFR_EE_CTRL, msf_pkg::EE_TX_CODE) |=> eeprom_tx_start)
		else $error("eeprom send not launched");
	a_wd_restart: assert property (sfr_we && sfr_addr == msf_pkg::SFR_WD_FLAGS && sfr_wdata[7] |=> watchdog_restart)
		else $error("watchdog not restarted");
	a_xfer_set: assert property (transfer_busy_event |=> transfer_event_flag)
		else $error("transfer flag not set");
endmodule : msf_sfr_asserts

// ### tb/tb_top.sv
// self-checking bench: AXI4-Lite controller driving the register group
`timescale 1ns/10ps
module tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [3:0]  wstrb = 4'h0;
	logic        debug_port_en = 1'b1, preboot_pin = 1'b0;
	logic [1:0]  ev = 2'b00, bresp, rresp, rsp;
	logic [6:0]  irq = 7'h00, page_erase_page;
	logic        awready, wready, bvalid, arready, rvalid, page_erase_start, mass_erase_start, flash_wr, data_ram_wr;
	logic        secure, eeprom_tx_start, watchdog_restart, transfer_event_flag, clock_second_event_flag;
	logic [15:0] mem_wr_addr;
	logic [7:0]  mem_wr_data, eeprom_data_byte, eeprom_command_control;
	int          fail_count = 0, checked = 0, cyc = 0;
	int          cnt [6], ex [6];
	msf_sfr_if   sif ();
	msf_mpu_ctrl u_msf_mpu_ctrl (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .bus(sif));
	msf_sfr_bank u_msf_sfr_bank (.aclk, .aresetn, .bus(sif), .debug_port_en, .page_erase_start, .page_erase_page,
		.mass_erase_start, .flash_wr, .data_ram_wr, .mem_wr_addr, .mem_wr_data, .secure, .preboot_pin, .eeprom_tx_start,
		.eeprom_data_byte, .eeprom_command_control, .transfer_busy_event(ev[0]), .one_second_tick(ev[1]),
		.watchdog_restart, .transfer_event_flag, .clock_second_event_flag, .external_irq_inputs(irq));
	msf_sfr_asserts u_msf_sfr_asserts (.aclk, .aresetn, .sfr_addr(sif.sfr_addr), .sfr_wdata(sif.sfr_wdata),
		.sfr_we(sif.sfr_we), .external_data_move_wr(sif.external_data_move_wr), .external_data_move_data(sif.external_data_move_data), .page_erase_start, .mass_erase_start,
		.flash_wr, .data_ram_wr, .mem_wr_data, .secure, .eeprom_tx_start, .watchdog_restart,
		.transfer_busy_event(ev[0]), .transfer_event_flag);
	// pulses are only one cycle wide, so they are tallied here and compared in bulk
	wire [5:0] pul = {page_erase_start, mass_erase_start, flash_wr, data_ram_wr, eeprom_tx_start, watchdog_restart};
	always #25 aclk = ~aclk;
	always @(posedge aclk) begin
		foreach (cnt[i]) cnt[i] <= cnt[i] + int'(aresetn && pul[i] === 1'b1);
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// trailing edge keeps a following request from re-driving a strobe in the same step
	task automatic aw(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask : aw
	task automatic ar(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : ar
	task automatic sw(input logic [7:0] a, input logic [7:0] d);
		aw(msf_pkg::CR_ADDR, {24'h0, a}, 4'hF, rsp);
		aw(msf_pkg::CR_WDATA, {24'h0, d}, 4'hF, rsp);
	endtask : sw
	task automatic sr(input logic [7:0] a, output logic [7:0] d);
		logic [31:0] t;
		aw(msf_pkg::CR_ADDR, {24'h0, a}, 4'hF, rsp);
		aw(msf_pkg::CR_RDCMD, 32'h0, 4'hF, rsp);
		do ar(msf_pkg::CR_RDATA, t, rsp); while (t[8] !== 1'b1);
		d = t[7:0];
	endtask : sr
	task automatic pc();
		repeat (2) @(posedge aclk);
		foreach (cnt[i]) chk(cnt[i], ex[i]);
	endtask : pc
	task give_verdict();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	initial begin
		logic [7:0] d, e, p;
		logic [7:0] ra [6] = '{8'hB7, 8'hB2, 8'hE8, 8'h9E, 8'h9F, 8'h94};
		void'($urandom(78));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (ra[i]) begin
			sr(ra[i], d);
			chk(d, 8'h00);
		end
		repeat (3) begin
			irq <= 7'($urandom);
			repeat (3) @(posedge aclk);
			sr(8'hF8, d);
			chk(d, {1'b0, irq});
		end
		for (int k = 0; k < 3; k++) begin
			p = (k == 0) ? 8'h00 : (k == 1) ? 8'h7F : {1'b0, 7'($urandom)};
			sw(8'hB7, p);
			sw(8'h94, msf_pkg::ERASE_PAGE_CODE);
			ex[5]++;
			pc();
			chk(page_erase_page, p);
			sr(8'hB7, d);
			chk(d, p);
		end
		repeat (4) begin
			e = 8'($urandom);
			if (e == 8'h55) e = 8'h56;
			sw(8'h94, e);
		end
		sw(8'h94, msf_pkg::ERASE_MASS_CODE);
		pc();
		sw(8'hB2, 8'h02);
		sw(8'h94, msf_pkg::ERASE_MASS_CODE);
		ex[4]++;
		pc();
		sw(8'h94, msf_pkg::ERASE_MASS_CODE);
		pc();
		sw(8'hB2, 8'h02);
		debug_port_en <= 1'b0;
		sw(8'h94, msf_pkg::ERASE_MASS_CODE);
		pc();
		debug_port_en <= 1'b1;
		aw(msf_pkg::CR_CTRL, 32'h1, 4'hF, rsp);
		sw(8'hB2, 8'h3D);
		sr(8'hB2, d);
		chk(d, 8'h00);
		sw(8'hB2, 8'h40);
		sw(8'hB2, 8'h00);
		sr(8'hB2, d);
		chk(d, 8'h40);
		chk(secure, 1'b1);
		aw(msf_pkg::CR_CTRL, 32'h0, 4'hF, rsp);
		sw(8'hB2, 8'h41);
		v = $urandom;
		aw(msf_pkg::CR_EXTERNAL_DATA_MOVE, {8'h00, v[23:0]}, 4'hF, rsp);
		ex[3]++;
		pc();
		chk({mem_wr_addr, mem_wr_data}, v[23:0]);
		sr(8'hB2, d);
		chk(d, 8'h40);
		aw(msf_pkg::CR_EXTERNAL_DATA_MOVE, {8'h00, v[23:0]}, 4'hF, rsp);
		ex[2]++;
		pc();
		preboot_pin <= 1'b1;
		repeat (3) @(posedge aclk);
		sr(8'hB2, d);
		chk(d, 8'hC0);
		preboot_pin <= 1'b0;
		e = 8'($urandom);
		sw(8'h9E, e);
		sw(8'h9F, msf_pkg::EE_TX_CODE);
		ex[1]++;
		pc();
		chk(eeprom_data_byte, e);
		sw(8'h9F, 8'h02);
		pc();
		chk(eeprom_command_control, 8'h02);
		for (int k = 0; k < 2; k++) begin
			ev <= 2'b01 << k;
			@(posedge aclk);
			ev <= 2'b00;
			sr(8'hE8, d);
			chk(d, k ? 8'h03 : 8'h01);
		end
		chk(clock_second_event_flag, 1'b1);
		// both flag writes below (0xFE, 0xFD) carry bit 7 set, so each one restarts the watchdog
		sw(8'hE8, 8'hFE);
		sr(8'hE8, d);
		chk(d, 8'h02);
		sw(8'hE8, 8'hFD);
		sr(8'hE8, d);
		chk(d, 8'h00);
		ex[0] += 2;
		pc();
		aw(msf_pkg::CR_WDATA, 32'hFF, 4'h1, rsp);
		chk(rsp, msf_pkg::RESP_SLVERR);
		// mid-run chip reset is the only way to drop the security bit
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(secure, 1'b0);
		sr(8'hB2, d);
		chk(d, 8'h00);
		sr(8'h80, d);
		chk(d, 8'h00);
		give_verdict();
	end
endmodule : tb_top
